// ### logic/stc_counter_unit.sv
// Purpose: 16-bit bidirectional counter core with byte-wide cpu access
// Assumes: cpu strobes and data are on clk_sys; tick pin is asynchronous
// Notes: compare and capture units supply their top values as inputs
`timescale 1ns/1ps
module stc_counter_unit
  import stc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [1:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic [PRESC_TAPS-1:0] prescale_tap,
  input wire logic tick_pin,
  input wire logic [15:0] top_compare_value,
  input wire logic [15:0] top_capture_value,
  input wire logic overflow_clear,
  output logic overflow_flag,
  output logic [15:0] count_value,
  output logic count_down,
  output logic top_hit,
  output logic bottom_hit,
  output logic timer_tick
);
  typedef struct packed {
    logic [15:0] count;
    logic [7:0] temp;
    logic [7:0] control_a;
    logic [7:0] control_b;
    logic down;
    logic ovf;
    logic [7:0] rdata;
  } stc_core_type;

  stc_core_type state;
  stc_core_type next_state;
  logic [3:0] waveform_mode_field;
  logic [15:0] top_value;
  logic dual_slope;
  logic ovf_at_max;
  logic wr_lower;
  logic wr_upper;
  logic rd_lower;
  logic rd_upper;
  logic tick;
  logic ovf_event;

  // ----------------------------------------
  // tick source
  // ----------------------------------------
  stc_tick_select i_stc_tick_select (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick_source_select(state.control_b[CTRL_B_SEL_LSB +: 3]),
    .prescale_tap(prescale_tap),
    .tick_pin(tick_pin),
    .timer_tick(tick)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign wr_lower = cpu_wr && (cpu_addr == LOC_COUNT_LOWER);
  assign wr_upper = cpu_wr && (cpu_addr == LOC_COUNT_UPPER);
  assign rd_lower = cpu_rd && (cpu_addr == LOC_COUNT_LOWER);
  assign rd_upper = cpu_rd && (cpu_addr == LOC_COUNT_UPPER);
  assign waveform_mode_field = {state.control_b[CTRL_B_WAVE_LSB +: 2],
                                state.control_a[CTRL_A_WAVE_LSB +: 2]};

  // ----------------------------------------
  // sequence shape per mode
  // ----------------------------------------
  always_comb
  begin
    case (waveform_mode_field)
      4'h1, 4'h5: top_value = TOP_8BIT;
      4'h2, 4'h6: top_value = TOP_9BIT;
      4'h3, 4'h7: top_value = TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top_value = top_compare_value;
      4'h8, 4'hA, 4'hC, 4'hE: top_value = top_capture_value;
      default: top_value = COUNT_MAX;
    endcase
    case (waveform_mode_field)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: dual_slope = 1'b1;
      default: dual_slope = 1'b0;
    endcase
    ovf_at_max = (waveform_mode_field == 4'h4) || (waveform_mode_field == 4'hC);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    ovf_event = 1'b0;
    // count operation on each active tick
    if (tick)
    begin
      if (dual_slope)
      begin
        if (!state.down)
        begin
          if (state.count >= top_value)
          begin
            next_state.down = 1'b1;
            next_state.count = state.count - 16'h0001;
          end
          else
          begin
            next_state.count = state.count + 16'h0001;
          end
        end
        else
        begin
          if (state.count == COUNT_BOTTOM)
          begin
            next_state.down = 1'b0;
            next_state.count = state.count + 16'h0001;
            ovf_event = 1'b1;
          end
          else
          begin
            next_state.count = state.count - 16'h0001;
          end
        end
      end
      else
      begin
        next_state.down = 1'b0;
        if (state.count == top_value)
        begin
          next_state.count = COUNT_BOTTOM;
          if (!ovf_at_max)
          begin
            ovf_event = 1'b1;
          end
        end
        else
        begin
          next_state.count = state.count + 16'h0001;
        end
        if (ovf_at_max && state.count == COUNT_MAX)
        begin
          ovf_event = 1'b1;
        end
      end
    end
    // flag set wins over a same-cycle clear
    if (ovf_event)
    begin
      next_state.ovf = 1'b1;
    end
    else if (overflow_clear)
    begin
      next_state.ovf = 1'b0;
    end
    // cpu reads
    if (rd_lower)
    begin
      next_state.rdata = state.count[7:0];
      next_state.temp = state.count[15:8];
    end
    else if (rd_upper)
    begin
      next_state.rdata = state.temp;
    end
    else if (cpu_rd && cpu_addr == LOC_CONTROL_A)
    begin
      next_state.rdata = state.control_a;
    end
    else if (cpu_rd)
    begin
      next_state.rdata = state.control_b;
    end
    // a lower-byte write overrides counting; other writes leave the count to the tick
    if (wr_lower)
    begin
      next_state.count = {state.temp, cpu_wdata};
    end
    else if (wr_upper)
    begin
      next_state.temp = cpu_wdata;
    end
    else if (cpu_wr && cpu_addr == LOC_CONTROL_A)
    begin
      next_state.control_a = cpu_wdata;
    end
    else if (cpu_wr)
    begin
      next_state.control_b = cpu_wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state.count <= COUNT_RESET;
      state.temp <= TEMP_RESET;
      state.control_a <= CTRL_RESET;
      state.control_b <= CTRL_RESET;
      state.down <= 1'b0;
      state.ovf <= 1'b0;
      state.rdata <= 8'h00;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cpu_rdata = state.rdata;
  assign count_value = state.count;
  assign count_down = state.down;
  assign overflow_flag = state.ovf;
  assign top_hit = (state.count == top_value);
  assign bottom_hit = (state.count == COUNT_BOTTOM);
  assign timer_tick = tick;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  AST_LOWER_WRITE_LOADS: assert property (
    wr_lower |=> state.count == {$past(state.temp), $past(cpu_wdata)})
    else $error("lower write did not load sixteen bits");
  AST_LOWER_READ_LATCHES: assert property (
    rd_lower && !cpu_wr |=> state.temp == $past(state.count[15:8])
      && cpu_rdata == $past(state.count[7:0]))
    else $error("lower read did not latch upper byte");
  AST_UPPER_READ_TEMP: assert property (
    rd_upper |=> cpu_rdata == $past(state.temp))
    else $error("upper read did not return temporary byte");
  AST_TEMP_KEPT: assert property (
    wr_lower && !rd_lower |=> $stable(state.temp))
    else $error("temporary byte changed after lower write");
  AST_STOPPED_HOLDS: assert property (
    state.control_b[2:0] == 3'h0 && !wr_lower |=> state.count == $past(state.count))
    else $error("count moved while stopped");
  AST_UP_STEP: assert property (
    tick && !wr_lower && !dual_slope && state.count != top_value
      |=> state.count == $past(state.count) + 16'h0001)
    else $error("up step not one");
  AST_DOWN_STEP: assert property (
    tick && !wr_lower && dual_slope && state.down && !bottom_hit
      |=> state.count == $past(state.count) - 16'h0001)
    else $error("down step not one");
  AST_CLEAR_AT_TOP: assert property (
    tick && !wr_lower && !dual_slope && top_hit |=> state.count == 16'h0000)
    else $error("no clear at top");
  AST_OVF_SET: assert property (
    tick && !wr_lower && !dual_slope && top_hit && !ovf_at_max |=> overflow_flag)
    else $error("overflow not set at top");
  AST_RESET_CLEARS: assert property (disable iff (1'b0)
    sys_rst |=> state.count == 16'h0000 && state.temp == 8'h00)
    else $error("reset did not clear count");
  AST_UPPER_WRITE_TEMP: assert property (
    wr_upper |=> state.temp == $past(cpu_wdata))
    else $error("upper write did not reach temporary byte");
  AST_UPPER_WRITE_KEEPS_COUNT: assert property (
    wr_upper && !tick |=> $stable(state.count))
    else $error("upper write moved the count");
  AST_WRITE_BEATS_TICK: assert property (
    wr_lower && tick |=> state.count == {$past(state.temp), $past(cpu_wdata)})
    else $error("tick beat a lower write");
  AST_READ_DATA_STANDS: assert property (
    !cpu_rd |=> $stable(cpu_rdata))
    else $error("read data changed without a read");
  AST_CONTROL_A_WRITE: assert property (
    cpu_wr && cpu_addr == LOC_CONTROL_A |=> state.control_a == $past(cpu_wdata))
    else $error("control a write lost");

  // ----------------------------------------
  // hold, direction and flag checks
  // ----------------------------------------
  AST_HOLD_WITHOUT_TICK: assert property (
    !tick && !wr_lower |=> $stable(state.count))
    else $error("count moved without a tick");
  AST_SINGLE_SLOPE_UP: assert property (
    tick && !dual_slope |=> !count_down)
    else $error("single slope counted down");
  AST_TURN_AT_TOP: assert property (
    tick && !wr_lower && dual_slope && !state.down && state.count >= top_value
      |=> count_down && state.count == $past(state.count) - 16'h0001)
    else $error("no turn at top");
  AST_TURN_AT_BOTTOM: assert property (
    tick && !wr_lower && dual_slope && state.down && bottom_hit
      |=> !count_down && overflow_flag && state.count == 16'h0001)
    else $error("no turn or flag at bottom");
  AST_OVF_AT_MAX: assert property (
    tick && !wr_lower && ovf_at_max && state.count == COUNT_MAX
      |=> overflow_flag && state.count == 16'h0000)
    else $error("no flag at absolute maximum");
  AST_SET_BEATS_CLEAR: assert property (
    ovf_event && overflow_clear |=> overflow_flag)
    else $error("flag clear beat a same-cycle set");
  AST_CLEAR_DROPS_FLAG: assert property (
    overflow_clear && !ovf_event |=> !overflow_flag)
    else $error("flag clear ignored");

  COV_TOP_WRAP: cover property (tick && top_hit && !dual_slope);
  COV_DUAL_TURN: cover property (tick && dual_slope && state.down && bottom_hit);
  COV_WRITE_BEATS_TICK: cover property (tick && wr_lower);
  COV_SET_MEETS_CLEAR: cover property (ovf_event && overflow_clear);
  COV_UPPER_WRITE_TICK: cover property (wr_upper && tick);
endmodule // stc_counter_unit

// ### logic/stc_counter_unit_dummy_placeholder_none.sv
// Purpose: tick source selector of the 16-bit counter unit
// Assumes: prescale taps are one-cycle enables on clk_sys; tick pin is asynchronous
// Notes: a pin edge reaches the counter three clock edges after the pin moves
`timescale 1ns/1ps
module stc_tick_select
  import stc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [2:0] tick_source_select,
  input wire logic [PRESC_TAPS-1:0] prescale_tap,
  input wire logic tick_pin,
  output logic timer_tick
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } stc_tick_state_type;

  stc_tick_state_type state;
  stc_tick_state_type next_state;
  logic rise;
  logic fall;

  // ----------------------------------------
  // pin synchroniser and edge memory
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_state.meta = tick_pin;
    next_state.sync = state.meta;
    next_state.prev = state.sync;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rise = state.sync & ~state.prev;
  assign fall = ~state.sync & state.prev;

  // ----------------------------------------
  // source choice
  // ----------------------------------------
  always_comb
  begin
    case (stc_sel_type'(tick_source_select))
      SEL_STOPPED: timer_tick = 1'b0;
      SEL_SYSTEM: timer_tick = 1'b1;
      SEL_TAP0: timer_tick = prescale_tap[0];
      SEL_TAP1: timer_tick = prescale_tap[1];
      SEL_TAP2: timer_tick = prescale_tap[2];
      SEL_TAP3: timer_tick = prescale_tap[3];
      SEL_PIN_FALL: timer_tick = fall;
      default: timer_tick = rise;
    endcase
  end

  AST_STOPPED_NO_TICK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick_source_select == 3'h0 |-> !timer_tick)
    else $error("tick seen with no source selected");
  AST_SYSTEM_TICK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick_source_select == 3'h1 |-> timer_tick)
    else $error("no tick with system clock selected");
endmodule // stc_tick_select

// ### logic/stc_pkg.sv
// Purpose: shared constants of the 16-bit counter unit and its tick source selector
// Assumes: one system clock; prescaler taps arrive as one-cycle enables on that clock
// Notes: constants and codes only; the tick selector sits in its own file
package stc_pkg;
  // ----------------------------------------
  // cpu location indices
  // ----------------------------------------
  localparam logic [1:0] LOC_COUNT_LOWER = 2'h0;
  localparam logic [1:0] LOC_COUNT_UPPER = 2'h1;
  localparam logic [1:0] LOC_CONTROL_A = 2'h2;
  localparam logic [1:0] LOC_CONTROL_B = 2'h3;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_A_WAVE_LSB = 0;
  localparam int CTRL_B_SEL_LSB = 0;
  localparam int CTRL_B_WAVE_LSB = 3;
  // ----------------------------------------
  // reset values and limits
  // ----------------------------------------
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam int PRESC_TAPS = 4;
  // ----------------------------------------
  // tick source codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    SEL_STOPPED = 3'h0,
    SEL_SYSTEM = 3'h1,
    SEL_TAP0 = 3'h2,
    SEL_TAP1 = 3'h3,
    SEL_TAP2 = 3'h4,
    SEL_TAP3 = 3'h5,
    SEL_PIN_FALL = 3'h6,
    SEL_PIN_RISE = 3'h7
  } stc_sel_type;
endpackage

// ### verif/sixteen_bit_counter_unit_bench.sv
// Purpose: self-checking bench of the 16-bit counter unit
// Assumes: tick pin, prescale taps and capture top move only in the source test
// Notes: counts are preloaded near the points under test
`timescale 1ns/1ps
module sixteen_bit_counter_unit_bench
  import stc_pkg::*;
;
  logic clk_sys;
  logic sys_rst;
  logic [1:0] cpu_addr;
  logic cpu_wr;
  logic cpu_rd;
  logic [7:0] cpu_wdata;
  logic [7:0] cpu_rdata;
  logic [15:0] top_compare_value;
  logic [15:0] top_capture_value;
  logic [PRESC_TAPS-1:0] prescale_tap;
  logic tick_pin;
  logic overflow_clear;
  logic overflow_flag;
  logic [15:0] count_value;
  logic count_down;
  logic top_hit;
  logic bottom_hit;
  logic timer_tick;
  logic [7:0] rb;
  int err_count = 0;
  int n_checks = 0;
  stc_counter_unit i_stc_counter_unit (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .prescale_tap(prescale_tap), .tick_pin(tick_pin),
    .top_compare_value(top_compare_value), .top_capture_value(top_capture_value),
    .overflow_clear(overflow_clear), .overflow_flag(overflow_flag),
    .count_value(count_value), .count_down(count_down), .top_hit(top_hit),
    .bottom_hit(bottom_hit), .timer_tick(timer_tick));
  stc_cpu_model i_stc_cpu_model (.clk_sys(clk_sys), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic pin_pulse();
    @(posedge clk_sys);
    tick_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    tick_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_for(input logic [15:0] v);
    int i;
    i = 0;
    while (count_value !== v && i < 20)
    begin
      step();
      i++;
    end
    if (count_value !== v)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, count_value, v);
      give_verdict();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(count_value, COUNT_RESET);
    chk(bottom_hit, 1'b1);
    i_stc_cpu_model.rd_byte(LOC_COUNT_LOWER, rb);
    chk(rb, 8'h00);
    i_stc_cpu_model.rd_byte(LOC_COUNT_UPPER, rb);
    chk(rb, TEMP_RESET);
    $display("reset test done");
  endtask
  task automatic t_access();
    i_stc_cpu_model.wr16(16'h01FF);
    chk(count_value, 16'h01FF);
    i_stc_cpu_model.rd_byte(LOC_COUNT_UPPER, rb);
    chk(rb, 8'h01);
    i_stc_cpu_model.wr_byte(LOC_COUNT_LOWER, 8'h10);
    chk(count_value, 16'h0110);
    i_stc_cpu_model.wr_byte(LOC_COUNT_UPPER, 8'hAB);
    chk(count_value, 16'h0110);
    i_stc_cpu_model.rd_byte(LOC_COUNT_LOWER, rb);
    chk(rb, 8'h10);
    i_stc_cpu_model.rd_byte(LOC_COUNT_UPPER, rb);
    chk(rb, 8'h01);
    $display("access test done");
  endtask
  task automatic t_count_up();
    logic [15:0] v;
    i_stc_cpu_model.wr16(16'hFFFD);
    i_stc_cpu_model.wr_byte(LOC_CONTROL_B, 8'h01);
    wait_for(16'hFFFE);
    step();
    chk(count_value, COUNT_MAX);
    chk(top_hit, 1'b1);
    step();
    chk(count_value, COUNT_BOTTOM);
    chk(overflow_flag, 1'b1);
    chk(bottom_hit, 1'b1);
    i_stc_cpu_model.wr16(16'h1234);
    chk(count_value, 16'h1234);
    step();
    chk(count_value, 16'h1235);
    i_stc_cpu_model.wr_byte(LOC_CONTROL_B, 8'h00);
    v = count_value;
    repeat (5) step();
    chk(count_value, v);
    chk(timer_tick, 1'b0);
    @(posedge clk_sys);
    overflow_clear <= 1'b1;
    @(posedge clk_sys);
    overflow_clear <= 1'b0;
    #1;
    chk(overflow_flag, 1'b0);
    $display("count up test done");
  endtask
  task automatic t_clear();
    @(posedge clk_sys);
    top_compare_value <= 16'h0005;
    i_stc_cpu_model.wr16(16'h0003);
    i_stc_cpu_model.wr_byte(LOC_CONTROL_B, 8'h09);
    wait_for(16'h0005);
    chk(top_hit, 1'b1);
    step();
    chk(count_value, 16'h0000);
    i_stc_cpu_model.wr_byte(LOC_CONTROL_B, 8'h00);
    $display("clear test done");
  endtask
  task automatic t_down();
    i_stc_cpu_model.wr_byte(LOC_CONTROL_A, 8'h01);
    i_stc_cpu_model.wr16(16'h00FD);
    i_stc_cpu_model.wr_byte(LOC_CONTROL_B, 8'h01);
    wait_for(TOP_8BIT);
    chk(top_hit, 1'b1);
    step();
    chk(count_value, 16'h00FE);
    chk(count_down, 1'b1);
    step();
    chk(count_value, 16'h00FD);
    i_stc_cpu_model.wr16(16'h0003);
    wait_for(COUNT_BOTTOM);
    chk(bottom_hit, 1'b1);
    step();
    chk(count_value, 16'h0001);
    chk(count_down, 1'b0);
    chk(overflow_flag, 1'b1);
    i_stc_cpu_model.wr_byte(LOC_CONTROL_B, 8'h00);
    $display("down test done");
  endtask
  task automatic t_sources();
    i_stc_cpu_model.wr_byte(LOC_CONTROL_A, 8'h00);
    i_stc_cpu_model.wr16(16'h0000);
    i_stc_cpu_model.wr_byte(LOC_CONTROL_B, 8'h02);
    repeat (3)
    begin
      @(posedge clk_sys);
      prescale_tap <= 4'h1;
      @(posedge clk_sys);
      prescale_tap <= 4'hE;
      @(posedge clk_sys);
      prescale_tap <= 4'h0;
    end
    #1;
    chk(count_value, 16'h0003);
    i_stc_cpu_model.wr_byte(LOC_CONTROL_B, 8'h07);
    repeat (2) pin_pulse();
    chk(count_value, 16'h0005);
    i_stc_cpu_model.wr_byte(LOC_CONTROL_B, 8'h06);
    repeat (2) pin_pulse();
    chk(count_value, 16'h0007);
    @(posedge clk_sys);
    top_capture_value <= 16'h0009;
    i_stc_cpu_model.wr_byte(LOC_CONTROL_A, 8'h02);
    i_stc_cpu_model.wr_byte(LOC_CONTROL_B, 8'h19);
    repeat (2)
    begin
      wait_for(16'h0008);
      @(posedge clk_sys);
      overflow_clear <= 1'b1;
      @(posedge clk_sys);
      overflow_clear <= 1'b0;
      #1;
      chk(count_value, COUNT_BOTTOM);
      chk(overflow_flag, 1'b1);
    end
    i_stc_cpu_model.wr_byte(LOC_CONTROL_B, 8'h00);
    $display("source test done");
  endtask
  initial
  begin
    sys_rst = 1'b1;
    top_compare_value = 16'hFFFF;
    overflow_clear = 1'b0;
    top_capture_value = 16'h0000;
    prescale_tap = 4'h0;
    tick_pin = 1'b0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    t_reset();
    t_access();
    t_count_up();
    t_clear();
    t_down();
    t_sources();
    give_verdict();
  end
endmodule // sixteen_bit_counter_unit_bench

// ### verif/stc_cpu_model.sv
// Purpose: cpu-side model of the byte-wide counter bus
// Assumes: one caller at a time, requests launched on a rising edge
// Notes: write data is scrambled while no write is pending
`timescale 1ns/1ps
module stc_cpu_model
  import stc_pkg::*;
(
  input wire logic clk_sys,
  output logic [1:0] cpu_addr,
  output logic cpu_wr,
  output logic cpu_rd,
  output logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata
);
  initial
  begin
    cpu_addr = 2'h0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = 8'hA5;
  end
  // ----------------------------------------
  // bus cycles, never interleaved
  // ----------------------------------------
  task automatic wr_byte(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
    cpu_wdata <= ~d;
    #1;
  endtask
  task automatic rd_byte(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk_sys);
    cpu_rd <= 1'b0;
    #1;
    d = cpu_rdata;
  endtask
  task automatic wr16(input logic [15:0] v);
    wr_byte(LOC_COUNT_UPPER, v[15:8]);
    wr_byte(LOC_COUNT_LOWER, v[7:0]);
  endtask
endmodule // stc_cpu_model
